// ---- adc_serial_pkg.sv ----
package adc_serial_pkg;

    // result word and configuration word sizes
    localparam int RES_W  = 21;
    localparam int BIN_W  = 20;
    localparam int CFG_W  = 12;
    localparam logic [3:0] CFG_BITS = 4'hC;

    // configuration field positions
    localparam int CFG_FMT_POS  = 0;
    localparam int CFG_RNG_POS  = 1;
    localparam int CFG_CONT_POS = 2;
    localparam int CFG_ACQ_LSB  = 3;
    localparam int CFG_OSR_LSB  = 5;
    localparam int CFG_INT_LSB  = 8;

    localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;

    // overflow flags clear one system cycle after data-valid rises
    localparam int OVF_CLR_DLY = 1;

    // synchronised pin bundle
    typedef struct packed {
        logic dclk;
        logic dataIn;
        logic cfgIn;
        logic xmitN;
        logic rdSel;
        logic cfgRstN;
        logic fpStart;
        logic selfTest;
    } pins_t;

    localparam int PINS_W = $bits(pins_t);

    // idle pin levels; the synchroniser resets to these
    localparam pins_t PINS_IDLE = 8'h1C;

    typedef struct packed {
        logic [3:0] integ;
        logic [2:0] osr;
        logic [1:0] acq;
        logic       cont;
        logic       bipolar;
        logic       straight;
    } cfg_t;

    typedef struct packed {
        logic dacOverPos;
        logic dacOverNeg;
        logic filtOverPos;
        logic filtOverNeg;
    } ovr_t;

endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
    parameter int           W       = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // asynchronous in, synchronised out
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            meta_q  <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule

// ---- charge_adc_serial_io.sv ----
`timescale 1ns/1ps
// Function
// - output register shifts data input through, passing upstream chained words after ours.
// - result sent as 21-bit two's complement or 20-bit straight binary.
// - result shifted out MSB first at the host's data clock rate.
// - data output high impedance unless transmit request is active.
// - data-valid rises at conversion end, holds until transmit request activates with readback select high.
// - over-range outputs are open-collector, only ever pulled active.
// - over-range flag set when feedback converter or filter exceeds full scale.
// - both over-range flags clear one system cycle after data-valid rises.
// - readback select high puts conversion result on data output.
// - readback select low loads configuration copy on data clock rising edges while transmit request is inactive.
// - configuration copy sits between data input and output, shifted like results.
// - configuration readback never corrupts held result or running conversion.
// - 12-bit configuration word sets acquisition, oversampling, integrations, range, format.
// - after configuration reset releases, next 12 rising data clocks load the word.
// - configuration reset clears only the configuration register.
// - self-check input connects test current source while high.
// - system reset resets everything but leaves configuration register unchanged.
// - final-point start begins collection; continuous mode integrates M cycles later.
// - data clock is independent of system clock, sampled as an asynchronous pin.
module charge_adc_serial_io
    import adc_serial_pkg::*;
(
    // clock and reset
    input  wire logic                              mclk,
    input  wire logic                              rstn,
    // host pins, asynchronous
    input  wire adc_serial_pkg::pins_t             pins,
    // serial data output, three-state
    output logic                                   doutO,
    output logic                                   doutOe,
    output logic                                   dataValid,
    // over-range open-collector pins
    output logic                                   ovfPosO,
    output logic                                   ovfPosOe,
    output logic                                   ovfNegO,
    output logic                                   ovfNegOe,
    // conversion core, same clock
    input  wire logic                              convDone,
    input  wire logic [adc_serial_pkg::RES_W-1:0]  result,
    input  wire adc_serial_pkg::ovr_t              ovr,
    output logic                                   collectStart,
    output logic                                   intStart,
    output adc_serial_pkg::cfg_t                   cfg,
    output logic                                   testCurrentEn
);
    import adc_serial_pkg::*;

    pins_t            pinS;
    logic             dclkPrev_q;
    logic             xmitPrev_q;
    logic             cfgRstPrev_q;
    logic             fpsPrev_q;
    logic             dclkRise;
    logic             dclkFall;
    logic             xmitAct;
    logic             xmitRise;
    logic             cfgRel;
    logic             fpsRise;
    logic [RES_W-1:0] resSh_q;
    logic [CFG_W-1:0] cfgSh_q;
    logic [CFG_W-1:0] cfg_q;
    logic [3:0]       cfgCnt_q;
    logic             dataValid_q;
    logic             ovfPos_q;
    logic             ovfNeg_q;
    logic             ovfClr_q;
    logic             dout_q;
    logic             resTap;
    logic [3:0]       intCnt_q;
    logic             intStart_q;
    logic             collect_q;

    // data clock is just another async pin here, sampled and edge-found
    // flops reset to idle pin levels: no false edge, no config clear in reset
    pin_sync #(
        .W       (PINS_W),
        .RST_VAL (PINS_IDLE)
    ) u_sync (
        .mclk    (mclk),
        .rstn    (rstn),
        .asyncIn (pins),
        .syncOut (pinS)
    );

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dclkPrev_q   <= 1'b0;
            xmitPrev_q   <= 1'b0;
            cfgRstPrev_q <= 1'b0;
            fpsPrev_q    <= 1'b0;
        end else begin
            dclkPrev_q   <= pinS.dclk;
            xmitPrev_q   <= xmitAct;
            cfgRstPrev_q <= !pinS.cfgRstN;
            fpsPrev_q    <= pinS.fpStart;
        end
    end

    assign dclkRise = pinS.dclk && !dclkPrev_q;
    assign dclkFall = !pinS.dclk && dclkPrev_q;
    assign xmitAct  = !pinS.xmitN;
    assign xmitRise = xmitAct && !xmitPrev_q;
    assign cfgRel   = cfgRstPrev_q && pinS.cfgRstN;
    assign fpsRise  = pinS.fpStart && !fpsPrev_q;

    // result shift register; a new conversion reloads it
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            resSh_q <= '0;
        end else if (convDone) begin
            if (cfg.straight) begin
                resSh_q <= {1'b0, result[BIN_W-1:0]};
            end else begin
                resSh_q <= result;
            end
        end else if (dclkRise && xmitAct && pinS.rdSel) begin
            resSh_q <= {resSh_q[RES_W-2:0], pinS.dataIn};
        end
    end

    // 20-bit words tap one stage early so chained data follows directly
    assign resTap = cfg.straight ? resSh_q[BIN_W-1] : resSh_q[RES_W-1];

    // readback copy is separate, so the held result is never touched
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cfgSh_q <= '0;
        end else if (dclkRise && !pinS.rdSel) begin
            if (xmitAct) begin
                cfgSh_q <= {cfgSh_q[CFG_W-2:0], pinS.dataIn};
            end else begin
                cfgSh_q <= cfg_q;
            end
        end
    end

    // output changes only after a falling edge or at transmit start
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dout_q <= 1'b0;
        end else if (dclkFall || xmitRise) begin
            dout_q <= pinS.rdSel ? resTap : cfgSh_q[CFG_W-1];
        end
    end

    assign doutO  = dout_q;
    assign doutOe = xmitAct;

    // configuration word: no system reset, only its own reset
    always_ff @(posedge mclk) begin
        if (!pinS.cfgRstN) begin
            cfg_q    <= CFG_RESET;
            cfgCnt_q <= '0;
        end else if (cfgRel) begin
            cfgCnt_q <= CFG_BITS;
        end else if (dclkRise && cfgCnt_q != 4'h0) begin
            cfg_q    <= {cfg_q[CFG_W-2:0], pinS.cfgIn};
            cfgCnt_q <= cfgCnt_q - 4'h1;
        end
    end

    assign cfg = cfg_t'(cfg_q);

    // set wins over the transmit clear
    // a readback frame leaves the held result valid
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            dataValid_q <= 1'b0;
        end else if (convDone) begin
            dataValid_q <= 1'b1;
        end else if (xmitRise && pinS.rdSel) begin
            dataValid_q <= 1'b0;
        end
    end

    assign dataValid = dataValid_q;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ovfClr_q <= 1'b0;
        end else begin
            ovfClr_q <= convDone;
        end
    end

    // an overrange arriving on the clear cycle is kept
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ovfPos_q <= 1'b0;
            ovfNeg_q <= 1'b0;
        end else begin
            if (ovr.dacOverPos || ovr.filtOverPos) begin
                ovfPos_q <= 1'b1;
            end else if (ovfClr_q) begin
                ovfPos_q <= 1'b0;
            end
            if (ovr.dacOverNeg || ovr.filtOverNeg) begin
                ovfNeg_q <= 1'b1;
            end else if (ovfClr_q) begin
                ovfNeg_q <= 1'b0;
            end
        end
    end

    // pulled low when flagged, released otherwise
    assign ovfPosO  = 1'b0;
    assign ovfNegO  = 1'b0;
    assign ovfPosOe = ovfPos_q;
    assign ovfNegOe = ovfNeg_q;

    // M = oversample code + 1 system cycles
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            collect_q  <= 1'b0;
            intCnt_q   <= '0;
            intStart_q <= 1'b0;
        end else begin
            collect_q  <= fpsRise;
            intStart_q <= 1'b0;
            if (fpsRise && cfg.cont) begin
                intCnt_q <= {1'b0, cfg.osr} + 4'h1;
            end else if (intCnt_q != 4'h0) begin
                intCnt_q <= intCnt_q - 4'h1;
                if (intCnt_q == 4'h1) begin
                    intStart_q <= 1'b1;
                end
            end
        end
    end

    assign collectStart  = collect_q;
    assign intStart      = intStart_q;
    assign testCurrentEn = pinS.selfTest;

    chk_valid_set: assert property (@(posedge mclk) disable iff (!rstn)
        convDone |=> dataValid) else $error("data-valid not set after conversion");
    chk_valid_hold: assert property (@(posedge mclk) disable iff (!rstn)
        dataValid && !xmitRise |=> dataValid) else $error("data-valid dropped early");
    chk_valid_clear: assert property (@(posedge mclk) disable iff (!rstn)
        xmitRise && pinS.rdSel && !convDone |=> !dataValid) else $error("data-valid not cleared");
    chk_dout_hiz: assert property (@(posedge mclk) disable iff (!rstn)
        doutOe == !$past(pins.xmitN, 2))
        else $error("output enable wrong");
    chk_ovf_clear: assert property (@(posedge mclk) disable iff (!rstn)
        convDone ##1 !(ovr.dacOverPos || ovr.filtOverPos) |=> !ovfPosOe)
        else $error("overflow not cleared");
    chk_ovf_set: assert property (@(posedge mclk) disable iff (!rstn)
        ovr.filtOverNeg |=> ovfNegOe && !ovfNegO) else $error("overflow not set");
    chk_shift_path: assert property (@(posedge mclk) disable iff (!rstn)
        dclkRise && xmitAct && pinS.rdSel && !convDone
        |=> resSh_q == {$past(resSh_q[RES_W-2:0]), $past(pinS.dataIn)})
        else $error("result shift wrong");
    chk_readback_keep: assert property (@(posedge mclk) disable iff (!rstn)
        !pinS.rdSel && !convDone |=> $stable(resSh_q)) else $error("result disturbed");
    chk_cfg_arm: assert property (@(posedge mclk) disable iff (!rstn)
        cfgRel |=> cfgCnt_q == 4'hC) else $error("config load not armed");
    chk_cfg_keep: assert property (@(posedge mclk) disable iff (!rstn)
        pinS.cfgRstN && cfgCnt_q == 4'h0 && !cfgRel |=> $stable(cfg_q))
        else $error("config changed outside load");
    chk_int_delay: assert property (@(posedge mclk) disable iff (!rstn)
        fpsRise && cfg.cont && cfg.osr == 3'h2 |=> ##3 intStart)
        else $error("integration start late");

    chk_first_bit: assert property (@(posedge mclk) disable iff (!rstn)
        xmitRise && pinS.rdSel && !cfg.straight |=> doutO == $past(resSh_q[RES_W-1]))
        else $error("first result bit wrong");
    chk_straight_load: assert property (@(posedge mclk) disable iff (!rstn)
        convDone && cfg.straight |=> resSh_q == {1'b0, $past(result[BIN_W-1:0])})
        else $error("straight word not loaded");
    chk_readback_load: assert property (@(posedge mclk) disable iff (!rstn)
        dclkRise && !pinS.rdSel && !xmitAct |=> cfgSh_q == $past(cfg_q))
        else $error("readback copy not loaded");
    chk_readback_chain: assert property (@(posedge mclk) disable iff (!rstn)
        dclkRise && xmitAct && !pinS.rdSel |=> cfgSh_q[0] == $past(pinS.dataIn))
        else $error("readback copy not chained");
    chk_dout_steady: assert property (@(posedge mclk) disable iff (!rstn)
        !dclkFall && !xmitRise |=> $stable(doutO))
        else $error("data output moved off a falling edge");
    // config checks need no system reset, the register ignores it
    chk_cfg_clear: assert property (@(posedge mclk)
        !pinS.cfgRstN |=> cfg_q == CFG_RESET)
        else $error("config not cleared");
    chk_cfg_shift: assert property (@(posedge mclk)
        pinS.cfgRstN && dclkRise && cfgCnt_q != 4'h0
        |=> cfg_q == {$past(cfg_q[CFG_W-2:0]), $past(pinS.cfgIn)})
        else $error("config bit not taken");
    chk_test_src: assert property (@(posedge mclk) disable iff (!rstn)
        testCurrentEn == $past(pins.selfTest, 2))
        else $error("test source not following its pin");
    chk_collect_pulse: assert property (@(posedge mclk) disable iff (!rstn)
        fpsRise |=> collectStart)
        else $error("collection not started");
    chk_int_single: assert property (@(posedge mclk) disable iff (!rstn)
        fpsRise && !cfg.cont && intCnt_q == 4'h0 |=> intCnt_q == 4'h0)
        else $error("integration armed in single mode");

    cov_transmit: cover property (@(posedge mclk) disable iff (!rstn)
        dataValid ##[1:50] xmitRise);
    cov_cfg_done: cover property (@(posedge mclk) disable iff (!rstn)
        cfgCnt_q == 4'h1 && dclkRise);
    cov_readback: cover property (@(posedge mclk) disable iff (!rstn)
        dclkRise && xmitAct && !pinS.rdSel);
    cov_overflow: cover property (@(posedge mclk) disable iff (!rstn)
        ovfPosOe ##1 convDone);
    cov_straight: cover property (@(posedge mclk) disable iff (!rstn)
        convDone && cfg.straight);
endmodule

// ---- host_model.sv ----
`timescale 1ns/1ps
module host_model (
    // host pins
    output logic      dclk,
    output logic      dataIn,
    output logic      cfgIn,
    output logic      xmitN,
    output logic      rdSel,
    output logic      cfgRstN,
    // device data pin
    input  wire logic doutO,
    input  wire logic doutOe
);
    logic line;

    // released pin floats; never let a stale level pass for data
    assign line = doutOe ? doutO : ~doutO;

    initial begin
        dclk    = 1'b0;
        dataIn  = 1'b0;
        cfgIn   = 1'b0;
        xmitN   = 1'b1;
        rdSel   = 1'b1;
        cfgRstN = 1'b1;
    end

    // data clock stands still between transfers, 64 ns period during config loads, readback preloads and frames
    task automatic loadCfg(input logic [11:0] w);
        cfgRstN = 1'b0;
        #40 cfgRstN = 1'b1;
        #60;
        for (int i = 11; i >= 0; i--) begin
            cfgIn = w[i];
            #32 dclk = 1'b1;
            #32 dclk = 1'b0;
        end
        cfgIn = ~cfgIn;
    endtask

    task automatic readBits(input logic rd, input int n, input logic [31:0] up,
                            output logic [63:0] got);
        got   = '0;
        rdSel = rd;
        if (!rd) begin
            #32 dclk = 1'b1;
            #32 dclk = 1'b0;
        end
        #32 xmitN = 1'b0;
        for (int i = 0; i < n; i++) begin
            dataIn = up[i];
            #32 dclk = 1'b1;
            got = {got[62:0], line};
            #32 dclk = 1'b0;
        end
        #32 xmitN = 1'b1;
        rdSel  = 1'b1;
        dataIn = ~dataIn;
        #40;
    endtask
endmodule

// ---- charge_adc_serial_io_bench.sv ----
`timescale 1ns/1ps
module charge_adc_serial_io_bench;
    import adc_serial_pkg::*;
    logic             mclk, rstn, convDone, fpStart, selfTest;
    logic             dclk, dataIn, cfgIn, xmitN, rdSel, cfgRstN;
    logic             doutO, doutOe, dataValid, ovfPosO, ovfPosOe, ovfNegO, ovfNegOe;
    logic             collectStart, intStart, testCurrentEn;
    logic [RES_W-1:0] result;
    logic [63:0]      got;
    ovr_t             ovr;
    pins_t            pins;
    cfg_t             cfg;
    int               error_cnt, checks, cycles;

    assign pins = {dclk, dataIn, cfgIn, xmitN, rdSel, cfgRstN, fpStart, selfTest};
    always #2 mclk = ~mclk;

    charge_adc_serial_io dut (.mclk(mclk), .rstn(rstn), .pins(pins), .doutO(doutO),
        .doutOe(doutOe), .dataValid(dataValid), .ovfPosO(ovfPosO), .ovfPosOe(ovfPosOe),
        .ovfNegO(ovfNegO), .ovfNegOe(ovfNegOe), .convDone(convDone), .result(result),
        .ovr(ovr), .collectStart(collectStart), .intStart(intStart), .cfg(cfg),
        .testCurrentEn(testCurrentEn));

    host_model host (.dclk(dclk), .dataIn(dataIn), .cfgIn(cfgIn), .xmitN(xmitN),
        .rdSel(rdSel), .cfgRstN(cfgRstN), .doutO(doutO), .doutOe(doutOe));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end

    task automatic convert(input logic [RES_W-1:0] r);
        @(negedge mclk);
        result   = r;
        convDone = 1'b1;
        @(negedge mclk);
        convDone = 1'b0;
    endtask

    task automatic t_cfg();
        host.loadCfg(12'hA5C);
        repeat (4) @(negedge mclk);
        check(cfg, 12'hA5C, "cfg load");
        rstn = 1'b0;
        repeat (3) @(negedge mclk);
        check(dataValid, 1'b0, "valid in reset");
        rstn = 1'b1;
        repeat (3) @(negedge mclk);
        check(cfg, 12'hA5C, "cfg after reset");
    endtask

    task automatic t_stream();
        convert(21'h1A2B3C);
        check(dataValid, 1'b1, "valid set");
        check(doutOe, 1'b0, "idle output");
        host.readBits(1'b1, 25, 32'h3, got);
        check(got[24:0], {21'h1A2B3C, 4'hC}, "result then chain");
        check(dataValid, 1'b0, "valid cleared");
        check(doutOe, 1'b0, "released");
    endtask

    task automatic t_readback();
        convert(21'h0F0F0);
        host.readBits(1'b0, 14, 32'h1, got);
        check(got[13:0], {12'hA5C, 2'b10}, "cfg readback");
        check(dataValid, 1'b1, "valid kept over readback");
        host.readBits(1'b1, 21, 32'h0, got);
        check(got[20:0], 21'h0F0F0, "result kept");
    endtask

    task automatic t_straight();
        convert(21'h155555);
        host.loadCfg(12'hA5D);
        check(dataValid, 1'b1, "valid kept");
        convert(21'h1ABCDE);
        host.readBits(1'b1, 22, 32'h1, got);
        check(got[21:0], {20'hABCDE, 2'b10}, "straight word");
    endtask

    task automatic t_ovf();
        @(negedge mclk);
        ovr = 4'h8;
        @(negedge mclk);
        ovr = 4'h1;
        @(negedge mclk);
        ovr = 4'h0;
        check({ovfPosOe, ovfNegOe, ovfPosO, ovfNegO}, 4'hC, "flags set");
        convert(21'h0);
        // flags captured on the valid strobe, before they clear
        check({dataValid, ovfPosOe, ovfNegOe}, 3'h7, "flags at strobe");
        @(negedge mclk);
        check({ovfPosOe, ovfNegOe}, 2'h0, "flags cleared");
    endtask

    task automatic t_misc();
        int gap;
        selfTest = 1'b1;
        repeat (4) @(negedge mclk);
        check(testCurrentEn, 1'b1, "test source on");
        selfTest = 1'b0;
        fpStart  = 1'b1;
        repeat (10) begin
            @(posedge mclk);
            #1;
            if (collectStart === 1'b1) break;
        end
        check(collectStart, 1'b1, "collect start");
        check(testCurrentEn, 1'b0, "test source off");
        for (gap = 0; gap < 10 && intStart !== 1'b1; gap++) begin
            @(posedge mclk);
            #1;
        end
        // oversampling code 2 in the loaded word, so three periods
        check(gap, 64'd3, "integration start gap");
        @(negedge mclk);
        fpStart = 1'b0;
    endtask

    task automatic t_single();
        int starts;
        int ints;
        host.loadCfg(12'hA59);
        starts = 0;
        ints   = 0;
        @(negedge mclk);
        fpStart = 1'b1;
        repeat (12) begin
            @(posedge mclk);
            #1;
            if (collectStart === 1'b1) starts++;
            if (intStart === 1'b1) ints++;
        end
        check(starts, 64'd1, "single collect start");
        check(ints, 64'd0, "no restart in single mode");
        @(negedge mclk);
        fpStart = 1'b0;
    endtask

    initial begin
        mclk      = 1'b0;
        rstn      = 1'b0;
        convDone  = 1'b0;
        fpStart   = 1'b0;
        selfTest  = 1'b0;
        result    = '0;
        ovr       = '0;
        error_cnt = 0;
        checks    = 0;
        cycles    = 0;
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        repeat (3) @(negedge mclk);
        t_cfg();
        t_stream();
        t_readback();
        t_straight();
        t_ovf();
        t_misc();
        t_single();
        results();
    end
endmodule
